// ### design/dacc_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "dacc_defs.svh"
module dacc_ctrl #(
	parameter int CONV_CYCLES = `DACC_CONV_CYCLES // conversion length
) (
	input  wire logic                   clk_i,          // 20 MHz clock
	input  wire logic                   reset_i,        // sync reset, high
	input  wire logic                   power_down_input_i, // power-down pin
	input  wire logic                   convert_start_input_i, // start pin
	input  wire logic                   chip_select_n_i, // bus enable, low
	input  wire logic                   shift_clock_in_i, // host shift clk
	input  wire logic                   serial_data_in_i, // config data in
	input  wire logic                   io_diff_sel_i,  // 1 diff, 0 single
	input  wire logic [`DACC_RES_W-1:0] ch0_result_i,   // ch0 digitised diff
	input  wire logic [`DACC_RES_W-1:0] ch1_result_i,   // ch1 digitised diff
	output logic                        busy_o,         // conversion running
	output logic                        hold_o,         // both s/h in hold
	output logic                        powered_down_o, // in power-down
	output logic                        global_reset_o, // internal reset pulse
	output logic                        diff_mode_o,    // io standard latched
	output logic                        bus_enable_o,   // serial bus driven
	output logic                        shift_clock_out_o, // forwarded clock
	output logic [`DACC_CFG_W-1:0]      span_cfg_o,     // active span word
	output logic [`DACC_RES_W-1:0]      ch0_data_o,     // ch0 result, gated
	output logic [`DACC_RES_W-1:0]      ch1_data_o      // ch1 result, gated
);
	// synchronised pins: power-down, start, cs, sck, sdi, io select
	logic [5:0] pins_s;
	logic       pd_s, cnv_s, cs_n_s, sck_s, sdi_s, diff_s;
	logic       cnv_q, sck_q, pd_q;    // previous samples for edge finding
	logic       cnv_rise, sck_rise, pd_rise;
	dacc_sync #(.WIDTH(6)) u_sync (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.d_i     ({power_down_input_i, convert_start_input_i,
		           chip_select_n_i, shift_clock_in_i,
		           serial_data_in_i, io_diff_sel_i}),
		.q_o     (pins_s)
	);
	assign {pd_s, cnv_s, cs_n_s, sck_s, sdi_s, diff_s} = pins_s;

	dacc_pkg::dacc_state_t state, next_state; // conversion control
	logic [9:0] conv_cnt;          // cycles left in conversion
	logic       conv_since_pd;     // a conversion ran since last power-down
	logic       soft_reset;        // combined reset for internal state
	logic [`DACC_CFG_W-1:0] cfg_shift; // incoming config bits
	logic [2:0] cfg_cnt;           // config bits received this frame
	logic       cs_q;              // previous chip select sample

	// edge history; cleared by reset_i only, the internal global reset leaves it
	assign soft_reset = reset_i | global_reset_o;
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			cnv_q <= 1'b0;
			sck_q <= 1'b0;
			pd_q  <= 1'b0;
			cs_q  <= 1'b1;
		end else begin
			cnv_q <= cnv_s;
			sck_q <= sck_s;
			pd_q  <= pd_s;
			cs_q  <= cs_n_s;
		end
	end
	// start edge taken regardless of chip select
	assign cnv_rise = cnv_s & ~cnv_q;
	assign sck_rise = sck_s & ~sck_q & ~cs_n_s;
	assign pd_rise  = pd_s & ~pd_q;

	// next-state logic; edges during busy are dropped as the host must wait
	always_comb begin
		next_state = state;
		case (state)
			dacc_pkg::DACC_IDLE: begin
				if (pd_s)
					next_state = dacc_pkg::DACC_DOWN;
				else if (cnv_rise)
					next_state = dacc_pkg::DACC_CONV;
			end
			dacc_pkg::DACC_CONV: begin
				// a power-down now waits until the count runs out
				if (conv_cnt == 10'h001)
					next_state = pd_s ? dacc_pkg::DACC_DOWN
					                  : dacc_pkg::DACC_IDLE;
			end
			dacc_pkg::DACC_DOWN: begin
				if (!pd_s)
					next_state = dacc_pkg::DACC_IDLE;
			end
			default: next_state = dacc_pkg::DACC_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (soft_reset)
			state <= dacc_pkg::DACC_IDLE;
		else
			state <= next_state;
	end

	// conversion timer, loaded at the start edge
	always_ff @(posedge clk_i) begin
		if (soft_reset)
			conv_cnt <= 10'h000;
		else if (state == dacc_pkg::DACC_IDLE &&
		         next_state == dacc_pkg::DACC_CONV)
			conv_cnt <= CONV_CYCLES[9:0];
		else if (conv_cnt != 10'h000)
			conv_cnt <= conv_cnt - 10'h001;
	end

	// busy and hold follow the converting state from its first cycle
	always_ff @(posedge clk_i) begin
		if (soft_reset) begin
			busy_o <= 1'b0;
			hold_o <= 1'b0;
		end else begin
			busy_o <= (next_state == dacc_pkg::DACC_CONV);
			hold_o <= (next_state == dacc_pkg::DACC_CONV);
		end
	end
	always_ff @(posedge clk_i) begin
		if (soft_reset)
			powered_down_o <= 1'b0;
		else
			powered_down_o <= (next_state == dacc_pkg::DACC_DOWN);
	end

	// second power-down with no conversion between fires a one-cycle reset
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			conv_since_pd  <= 1'b1;
			global_reset_o <= 1'b0;
		end else begin
			global_reset_o <= pd_rise & ~conv_since_pd;
			// global reset acts like power-on, so the pair count restarts
			if (global_reset_o)
				conv_since_pd <= 1'b1;
			else if (pd_rise)
				conv_since_pd <= 1'b0;
			else if (state == dacc_pkg::DACC_CONV)
				conv_since_pd <= 1'b1;
		end
	end

	// io standard is static; sampled continuously after sync
	always_ff @(posedge clk_i) begin
		if (reset_i)
			diff_mode_o <= 1'b0;
		else
			diff_mode_o <= diff_s;
	end
	always_ff @(posedge clk_i) begin
		if (reset_i)
			bus_enable_o <= 1'b0;
		else
			bus_enable_o <= ~cs_n_s;
	end

	// forwarded clock toggles per gated rising edge, half rate;
	// cleared when busy falls in single-ended mode so the host knows its phase
	always_ff @(posedge clk_i) begin
		if (soft_reset)
			shift_clock_out_o <= 1'b0;
		else if (busy_o && next_state != dacc_pkg::DACC_CONV && !diff_s)
			shift_clock_out_o <= 1'b0;
		else if (sck_rise)
			shift_clock_out_o <= ~shift_clock_out_o;
	end

	// config word shifted msb first on gated shift clock edges;
	// applied when six bits are in and chip select rises
	always_ff @(posedge clk_i) begin
		if (soft_reset) begin
			cfg_shift  <= `DACC_CFG_RESET;
			cfg_cnt    <= 3'h0;
			span_cfg_o <= `DACC_CFG_RESET;
		end else begin
			if (cs_n_s)
				cfg_cnt <= 3'h0;
			else if (sck_rise && cfg_cnt != 3'(`DACC_CFG_W)) begin
				cfg_shift <= {cfg_shift[`DACC_CFG_W-2:0], sdi_s};
				cfg_cnt   <= cfg_cnt + 3'h1;
			end
			if (cs_n_s && !cs_q && cfg_cnt == 3'(`DACC_CFG_W))
				span_cfg_o <= cfg_shift;
		end
	end

	// results captured at end of conversion; disabled channel reads zero
	always_ff @(posedge clk_i) begin
		if (soft_reset) begin
			ch0_data_o <= '0;
			ch1_data_o <= '0;
		end else if (state == dacc_pkg::DACC_CONV && conv_cnt == 10'h001) begin
			ch0_data_o <= (span_cfg_o[`DACC_CODE_W-1:0] == `DACC_CODE_OFF)
			              ? '0 : ch0_result_i;
			ch1_data_o <= (span_cfg_o[`DACC_CFG_W-1:`DACC_CODE_W] ==
			               `DACC_CODE_OFF) ? '0 : ch1_result_i;
		end
	end
endmodule : dacc_ctrl
`default_nettype wire

// ### design/dacc_defs.svh
`ifndef DACC_DEFS_SVH
`define DACC_DEFS_SVH
// conversion length in cycles of clk_i (internal conversion clock)
`define DACC_CONV_CYCLES   10'h020
// width of one channel's range code and of the configuration word
`define DACC_CODE_W        3
`define DACC_CFG_W         6
// range code that disables a channel
`define DACC_CODE_OFF      3'h0
// configuration word after reset: both channels at widest bipolar span
`define DACC_CFG_RESET     6'h3f
// result width of one channel
`define DACC_RES_W         16
`endif

// ### design/dacc_pkg.sv
package dacc_pkg;
	// conversion control states
	typedef enum logic [1:0] {
		DACC_IDLE,
		DACC_CONV,
		DACC_DOWN
	} dacc_state_t;
endpackage : dacc_pkg

// ### design/dacc_sync.sv
`timescale 1ns/1ns
`default_nettype none
// two-flop synchroniser bank; first stage is read only by the second
module dacc_sync #(
	parameter int WIDTH = 1              // number of bits
) (
	input  wire logic             clk_i, // system clock
	input  wire logic             reset_i, // sync reset, high
	input  wire logic [WIDTH-1:0] d_i,   // asynchronous inputs
	output logic      [WIDTH-1:0] q_o    // synchronised outputs
);
	logic [WIDTH-1:0] meta; // first stage
	// one generate slice per bit keeps each path independent
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			always_ff @(posedge clk_i) begin
				if (reset_i) begin
					meta[g] <= 1'b0;
					q_o[g]  <= 1'b0;
				end else begin
					meta[g] <= d_i[g];
					q_o[g]  <= meta[g];
				end
			end
		end
	endgenerate
endmodule : dacc_sync
`default_nettype wire

// ### tb/dacc_ctrl_asserts.sv
`timescale 1ns/1ns
`default_nettype none
`include "dacc_defs.svh"
// port-level checks of conversion timing, power-down and reset pulses
module dacc_ctrl_asserts #(
	parameter int CONV_CYCLES = 32 // conversion length
) (
	input wire logic        clk_i,                 // system clock
	input wire logic        reset_i,               // sync reset, high
	input wire logic        convert_start_input_i, // start pin
	input wire logic        busy_o,                // conversion running
	input wire logic        hold_o,                // s/h in hold
	input wire logic        powered_down_o,        // in power-down
	input wire logic        global_reset_o,        // reset pulse
	input wire logic        diff_mode_o,           // io standard
	input wire logic        shift_clock_out_o,     // forwarded clock
	input wire logic [5:0]  span_cfg_o,            // span word
	input wire logic [15:0] ch0_data_o,            // ch0 result
	input wire logic [15:0] ch1_data_o             // ch1 result
);
	logic [9:0] run_len; // cycles busy has stood high so far
	// counter instead of a long repetition, which tools unroll badly
	always_ff @(posedge clk_i) begin
		if (reset_i || !busy_o)
			run_len <= 10'h000;
		else
			run_len <= run_len + 10'h001;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	sequence s_conv_start; $rose(busy_o); endsequence
	sequence s_conv_end; $fell(busy_o); endsequence
	chk_busy_len: assert property (s_conv_end |-> run_len == 10'(CONV_CYCLES))
		else $error("busy length wrong");
	chk_hold_busy: assert property (hold_o == busy_o)
		else $error("hold differs from busy");
	chk_start_edge: assert property (s_conv_start |-> $past(convert_start_input_i, 2))
		else $error("busy rose without start");
	chk_pd_refuse: assert property (s_conv_start |-> !$past(powered_down_o))
		else $error("conversion while powered down");
	chk_pd_waits: assert property (busy_o |-> !powered_down_o)
		else $error("power-down before conversion end");
	chk_sck_low: assert property (s_conv_end ##0 !diff_mode_o |-> !shift_clock_out_o)
		else $error("shift clock not low at busy fall");
	chk_grst_pulse: assert property (global_reset_o |=> !global_reset_o)
		else $error("reset pulse too long");
	chk_grst_clear: assert property (global_reset_o |-> ##[1:2] (span_cfg_o == `DACC_CFG_RESET && !busy_o))
		else $error("reset did not clear state");
	chk_off_zero0: assert property (s_conv_end ##0 span_cfg_o[2:0] == `DACC_CODE_OFF |-> ch0_data_o == 16'h0000)
		else $error("disabled ch0 not zero");
	chk_off_zero1: assert property (s_conv_end ##0 span_cfg_o[5:3] == `DACC_CODE_OFF |-> ch1_data_o == 16'h0000)
		else $error("disabled ch1 not zero");
endmodule : dacc_ctrl_asserts
bind dacc_ctrl dacc_ctrl_asserts #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
	.clk_i(clk_i), .reset_i(reset_i), .busy_o(busy_o), .hold_o(hold_o),
	.convert_start_input_i(convert_start_input_i), .diff_mode_o(diff_mode_o),
	.powered_down_o(powered_down_o), .global_reset_o(global_reset_o),
	.shift_clock_out_o(shift_clock_out_o), .span_cfg_o(span_cfg_o),
	.ch0_data_o(ch0_data_o), .ch1_data_o(ch1_data_o));
`default_nettype wire

// ### tb/dacc_ctrl_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module dacc_ctrl_tb_top;
	logic        clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        pd, convert_start_input, io_sel, go, cs_n, sck, sdi, busy, pdn, grst, dmode;
	logic        ben;
	logic [2:0]  nb;
	logic [5:0]  word, span;
	logic [15:0] r0, r1, d0, d1;
	logic [31:0] seed = 32'h00000d7f;
	logic [31:0] expq[$]; // expected {ch1, ch0} per conversion
	logic        was_busy = 1'b0;
	int          failures = 0, samples_checked = 0, grst_seen = 0;
	always #25 clk_i = ~clk_i;
	dacc_ctrl #(.CONV_CYCLES(32)) u_dut (.clk_i(clk_i), .reset_i(reset_i),
		.power_down_input_i(pd), .convert_start_input_i(convert_start_input),
		.chip_select_n_i(cs_n), .shift_clock_in_i(sck), .serial_data_in_i(sdi),
		.io_diff_sel_i(io_sel), .ch0_result_i(r0), .ch1_result_i(r1),
		.busy_o(busy), .hold_o(), .powered_down_o(pdn), .global_reset_o(grst),
		.diff_mode_o(dmode), .bus_enable_o(ben), .shift_clock_out_o(),
		.span_cfg_o(span), .ch0_data_o(d0), .ch1_data_o(d1));
	dacc_host_model u_host (.go_i(go), .word_i(word), .nbits_i(nb),
		.cs_n_o(cs_n), .sck_o(sck), .sdi_o(sdi));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tick
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic summarize;
		$display("checks=%0d failures=%0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize
	// one conversion with random results; a second start lands while busy
	task automatic conv(input logic [2:0] c0, input logic [2:0] c1, input logic pdm);
		seed = xs(seed);
		r0 <= seed[15:0];
		r1 <= seed[31:16];
		convert_start_input <= 1'b1;
		expq.push_back({(c1 == 3'h0) ? 16'h0000 : seed[31:16],
			(c0 == 3'h0) ? 16'h0000 : seed[15:0]});
		tick(10);
		convert_start_input <= 1'b0;
		pd <= pdm;
		tick(3);
		convert_start_input <= 1'b1;
		tick(3);
		convert_start_input <= 1'b0;
		tick(30);
	endtask : conv
	task automatic frame(input logic [5:0] w, input logic [2:0] n);
		word <= w;
		nb <= n;
		go <= 1'b1;
		tick(1);
		go <= 1'b0;
		tick(10);
		chk(32'(ben), 32'h1);
		tick(8 * n - 2);
	endtask : frame
	// scoreboard: each busy fall consumes the oldest expected pair
	always @(negedge clk_i) begin
		if (was_busy && !busy) begin
			if (expq.size() == 0) chk(32'h1, 32'h0);
			else chk({d1, d0}, expq.pop_front());
		end
		was_busy = busy;
	end
	always @(posedge clk_i) if (grst === 1'b1) grst_seen++;
	initial begin
		#200000;
		failures++;
		summarize;
	end
	initial begin
		{pd, convert_start_input, io_sel, go, r0, r1, word, nb} = '0;
		tick(16);
		reset_i <= 1'b0;
		tick(4);
		chk(32'(span), 32'h3f);
		chk(32'(dmode), 32'h0);
		chk(32'(ben), 32'h0);
		$display("test reset done");
		conv(3'h7, 3'h7, 1'b0);
		$display("test convert done");
		frame(6'h05, 3'd5);
		chk(32'(span), 32'h3f);
		frame(6'h05, 3'd6);
		chk(32'(span), 32'h05);
		conv(3'h5, 3'h0, 1'b0);
		$display("test config done");
		conv(3'h5, 3'h0, 1'b1);
		chk(32'(pdn), 32'h1);
		convert_start_input <= 1'b1;
		tick(8);
		convert_start_input <= 1'b0;
		tick(40);
		pd <= 1'b0;
		tick(4);
		pd <= 1'b1;
		tick(4);
		pd <= 1'b0;
		tick(4);
		pd <= 1'b1;
		tick(8);
		chk(32'(grst_seen != 0), 32'h1);
		chk(32'(span), 32'h3f);
		$display("test power down done");
		io_sel <= 1'b1;
		tick(4);
		chk(32'(dmode), 32'h1);
		$display("test io mode done");
		summarize;
	end
endmodule : dacc_ctrl_tb_top
`default_nettype wire

// ### tb/dacc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// host side of the serial bus: one frame of msb-first bits per go pulse
module dacc_host_model (
	input  wire logic       go_i,    // start one frame
	input  wire logic [5:0] word_i,  // bits, msb first
	input  wire logic [2:0] nbits_i, // bits in the frame
	output logic            cs_n_o,  // chip select, low
	output logic            sck_o,   // shift clock
	output logic            sdi_o    // serial data
);
	initial begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		sdi_o = 1'b0;
	end
	// clock parks low outside frames; 400 ns period, far above the minimum
	always @(posedge go_i) begin
		cs_n_o = 1'b0;
		for (int i = 5; i > 5 - int'(nbits_i); i--) begin
			sdi_o = word_i[i];
			#200 sck_o = 1'b1;
			#200 sck_o = 1'b0;
		end
		#130 cs_n_o = 1'b1;
		sdi_o = ~sdi_o; // released line must not keep its last bit
	end
endmodule : dacc_host_model
`default_nettype wire
